// [hdl/spr_defs.svh]
// Constants for the serial programming and read-back port
`ifndef SPR_DEFS_SVH
`define SPR_DEFS_SVH
// Serial command codes
`define SPR_CMD_CORE 4'h0
`define SPR_CMD_SHOUT 4'h2
`define SPR_CMD_TRD 4'h9
`define SPR_CMD_WRINC 4'hd
`define SPR_CMD_WRPRG 4'hf
// Bit counts within a frame
`define SPR_CMD_LAST 5'h03
`define SPR_TURN 5'h07
`define SPR_PAY_LAST 5'h0f
// Core opcodes
`define SPR_OP_MOVLW 8'h0e
`define SPR_OP_MOVWF 8'h6e
`define SPR_OP_MOVF 8'h50
`define SPR_OP_BITOP 3'h4
// Special function register addresses
`define SPR_SFR_TPU 8'hf8
`define SPR_SFR_TPH 8'hf7
`define SPR_SFR_TPL 8'hf6
`define SPR_SFR_HOLD 8'hf5
`define SPR_SFR_EEL 8'ha9
`define SPR_SFR_EEH 8'haa
`define SPR_SFR_EED 8'ha8
`define SPR_SFR_NVC 8'ha6
// Control register bits
`define SPR_NVC_FLASH 7
`define SPR_NVC_CONFIG_SPACE_SELECT_BIT 6
`define SPR_NVC_RD 3'h0
// Programming address space
`define SPR_ID_BASE 22'h200000
`define SPR_ID_LAST 22'h200007
`define SPR_ID_N 8
`define SPR_CFG_PAGE 18'h30000
`define SPR_CFG_N 16
`define SPR_PROT_IDX 4'hb
`define SPR_CONFIG_WRITE_PROTECT_BIT_BIT 5
`define SPR_CFG_RST 8'hff
// Erased data cells read as all ones
`define SPR_EE_BLANK 8'hff
// Register bus map
`define SPR_A_CTRL 8'h00
`define SPR_A_STAT 8'h04
`define SPR_A_PTR 8'h08
`define SPR_A_HOLD 8'h0c
`define SPR_CTRL_RST 1'b1
`define SPR_OKAY 2'h0
`define SPR_SLVERR 2'h2
`endif

// [hdl/spr_pkg.sv]
// Types shared by the serial programming port
`default_nettype none
package spr_pkg;
  typedef enum logic [1:0] {SPR_OFF = 2'h0, SPR_CMD = 2'h1, SPR_PAY = 2'h3} spr_state_t;
  typedef enum logic [1:0] {SPR_RG_NONE, SPR_RG_CODE, SPR_RG_ID, SPR_RG_CFG} spr_region_t;
  typedef struct packed {
    logic dout;
    logic oe;
  } spr_pin_t;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] arg;
  } spr_word_t;
endpackage : spr_pkg
`default_nettype wire

// [hdl/spr_serial_port.sv]
// Serial programming and read-back port with register bus
`include "spr_defs.svh"
`default_nettype none
module spr_serial_port #(
  parameter int CODE_BYTES = 1024,
  parameter int EE_BYTES = 256,
  parameter int WBUF_BYTES = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  output var spr_pkg::spr_pin_t prog_serial_data_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import spr_pkg::*;
  localparam int CW = $clog2(CODE_BYTES);
  localparam int EW = $clog2(EE_BYTES);
  localparam int BW = $clog2(WBUF_BYTES);
  localparam logic [21:0] CODE_END = 22'(CODE_BYTES);

  if ((1 << CW) != CODE_BYTES || (1 << BW) != WBUF_BYTES || BW < 2 ||
      CODE_BYTES <= WBUF_BYTES || (1 << EW) != EE_BYTES || EW > 16)
  begin : g_bad_param
    $error("spr_serial_port: unsupported memory sizes");
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [2:0] clk_sync;
  logic [1:0] dat_sync;
  logic fall, rise, din;
  spr_state_t state;
  logic [4:0] cnt;
  logic [3:0] cmd_sr, cmd;
  logic [15:0] pay_sr;
  logic [3:0] next_cmd;
  spr_word_t next_pay;
  logic cmd_done, pay_done, turn, is_read, commit;
  logic enable;
  logic [21:0] tp;
  logic [7:0] wreg, hold, eel, eeh, eed, nvc;
  logic [7:0] code_mem [CODE_BYTES];
  logic [7:0] ee_mem [EE_BYTES];
  logic [7:0] id_mem [`SPR_ID_N];
  logic [7:0] cfg_mem [`SPR_CFG_N];
  logic [7:0] wbuf [WBUF_BYTES];
  logic pend, pend_cfg;
  logic [21:0] pend_base;
  logic [7:0] pend_byte, rd_byte, out_sr, cfg_cur;
  logic wp, flash_wr, cfg_wr;

  function automatic spr_region_t region_of(input logic [21:0] a);
    region_of = SPR_RG_NONE;
    if (a < CODE_END)
      region_of = SPR_RG_CODE;
    else if (a >= `SPR_ID_BASE && a <= `SPR_ID_LAST)
      region_of = SPR_RG_ID;
    else if (a[21:4] == `SPR_CFG_PAGE)
      region_of = SPR_RG_CFG;
  endfunction : region_of

  // ==========================================================
  // Pin synchronisers and edge detection
  // Stages 2 and 1 feed the edge compare; stage 0 is read only by stage 1
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      clk_sync <= 3'h0;
      dat_sync <= 2'h0;
    end
    else
    begin
      clk_sync <= {clk_sync[1:0], prog_serial_clock};
      dat_sync <= {dat_sync[0], prog_serial_data_in};
    end
  end

  assign fall = clk_sync[2] & ~clk_sync[1];
  assign rise = ~clk_sync[2] & clk_sync[1];
  assign din = dat_sync[1];
  assign next_cmd = {din, cmd_sr[3:1]};
  assign next_pay = spr_word_t'({din, pay_sr[15:1]});
  assign cmd_done = fall && state == SPR_CMD && cnt == `SPR_CMD_LAST;
  assign pay_done = fall && state == SPR_PAY && cnt == `SPR_PAY_LAST;
  assign is_read = cmd == `SPR_CMD_TRD || cmd == `SPR_CMD_SHOUT;
  assign turn = fall && state == SPR_PAY && is_read && cnt == `SPR_TURN;
  assign commit = cmd_done && pend;

  // ==========================================================
  // Frame sequencer: 4 command bits then 16 payload bits
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= SPR_OFF;
      cnt <= 5'h00;
      cmd_sr <= 4'h0;
      cmd <= 4'h0;
      pay_sr <= 16'h0000;
    end
    else if (!enable)
    begin
      state <= SPR_OFF;
      cnt <= 5'h00;
    end
    else
    begin
      case (state)
        SPR_OFF:
        begin
          state <= SPR_CMD;
          cnt <= 5'h00;
        end
        SPR_CMD:
          if (fall)
          begin
            cmd_sr <= next_cmd;
            cnt <= cmd_done ? 5'h00 : cnt + 5'h01;
            if (cmd_done)
            begin
              cmd <= next_cmd;
              state <= SPR_PAY;
            end
          end
        SPR_PAY:
          if (fall)
          begin
            pay_sr <= next_pay;
            cnt <= pay_done ? 5'h00 : cnt + 5'h01;
            if (pay_done)
              state <= SPR_CMD;
          end
        default:
          state <= SPR_OFF;
      endcase
    end
  end

  // ==========================================================
  // Core instruction executor and pointers
  assign flash_wr = pay_done && nvc[`SPR_NVC_FLASH] && !nvc[`SPR_NVC_CONFIG_SPACE_SELECT_BIT] &&
                    (cmd == `SPR_CMD_WRINC || cmd == `SPR_CMD_WRPRG);
  assign cfg_wr = pay_done && nvc[`SPR_NVC_CONFIG_SPACE_SELECT_BIT] && cmd == `SPR_CMD_WRPRG;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tp <= 22'h000000;
      wreg <= 8'h00;
      hold <= 8'h00;
      eel <= 8'h00;
      eeh <= 8'h00;
      eed <= 8'h00;
      nvc <= 8'h00;
      // No write path here, so the array holds the erased image
      for (int i = 0; i < EE_BYTES; i++)
        ee_mem[i] <= `SPR_EE_BLANK;
    end
    else if (pay_done && cmd == `SPR_CMD_CORE)
    begin
      if (next_pay.op == `SPR_OP_MOVLW)
        wreg <= next_pay.arg;
      else if (next_pay.op == `SPR_OP_MOVWF)
        case (next_pay.arg)
          `SPR_SFR_TPU: tp[21:16] <= wreg[5:0];
          `SPR_SFR_TPH: tp[15:8] <= wreg;
          `SPR_SFR_TPL: tp[7:0] <= wreg;
          `SPR_SFR_HOLD: hold <= wreg;
          `SPR_SFR_EEL: eel <= wreg;
          `SPR_SFR_EEH: eeh <= wreg;
          `SPR_SFR_EED: eed <= wreg;
          `SPR_SFR_NVC: nvc <= wreg;
          default: ;
        endcase
      else if (next_pay.op == `SPR_OP_MOVF)
        case (next_pay.arg)
          `SPR_SFR_EED: wreg <= eed;
          `SPR_SFR_NVC: wreg <= nvc;
          `SPR_SFR_HOLD: wreg <= hold;
          default: wreg <= 8'h00;
        endcase
      else if (next_pay.op[7:5] == `SPR_OP_BITOP && next_pay.arg == `SPR_SFR_NVC)
      begin
        // Read strobe self-clears, so a bit set of it is never stored
        if (!next_pay.op[4] && next_pay.op[3:1] == `SPR_NVC_RD)
          eed <= ee_mem[EW'({eeh, eel})];
        else
          nvc[next_pay.op[3:1]] <= ~next_pay.op[4];
      end
    end
    else if (flash_wr && cmd == `SPR_CMD_WRINC)
      tp <= tp + 22'h000002;
    else if (turn && cmd == `SPR_CMD_TRD)
      tp <= tp + 22'h000001;
  end

  // ==========================================================
  // Write buffer and nonvolatile arrays
  assign wp = cfg_mem[`SPR_PROT_IDX][`SPR_CONFIG_WRITE_PROTECT_BIT_BIT] == 1'b0;
  assign cfg_cur = cfg_mem[pend_base[3:0]];

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pend <= 1'b0;
      pend_cfg <= 1'b0;
      pend_base <= 22'h000000;
      pend_byte <= 8'h00;
      for (int i = 0; i < `SPR_CFG_N; i++)
        cfg_mem[i] <= `SPR_CFG_RST;
    end
    else if (flash_wr)
    begin
      wbuf[{tp[BW-1:1], 1'b0}] <= next_pay.arg;
      wbuf[{tp[BW-1:1], 1'b1}] <= next_pay.op;
      if (cmd == `SPR_CMD_WRPRG)
      begin
        pend <= 1'b1;
        pend_cfg <= 1'b0;
        pend_base <= {tp[21:BW], {BW{1'b0}}};
      end
    end
    else if (cfg_wr)
    begin
      pend <= 1'b1;
      pend_cfg <= 1'b1;
      pend_base <= tp;
      pend_byte <= tp[0] ? next_pay.op : next_pay.arg;
    end
    else if (commit)
    begin
      // Commit waits for the falling clock that closes the hold
      pend <= 1'b0;
      if (pend_cfg)
      begin
        if (region_of(pend_base) == SPR_RG_CFG && !wp)
          cfg_mem[pend_base[3:0]] <= pend_byte;
      end
      else
        for (int i = 0; i < WBUF_BYTES; i++)
        begin
          if (region_of(pend_base) == SPR_RG_CODE)
            code_mem[{pend_base[CW-1:BW], BW'(i)}] <= wbuf[i];
          else if (region_of(pend_base) == SPR_RG_ID && i < `SPR_ID_N)
            id_mem[i[2:0]] <= wbuf[i];
        end
    end
  end

  always_comb
  begin
    rd_byte = 8'hff;
    case (region_of(tp))
      SPR_RG_CODE: rd_byte = code_mem[tp[CW-1:0]];
      SPR_RG_ID: rd_byte = id_mem[tp[2:0]];
      SPR_RG_CFG: rd_byte = cfg_mem[tp[3:0]];
      default: rd_byte = 8'hff;
    endcase
  end

  // ==========================================================
  // Read-back shifter; first payload byte is left undriven
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      out_sr <= 8'h00;
      prog_serial_data_out <= '0;
    end
    else if (pay_done || !enable)
      prog_serial_data_out.oe <= 1'b0;
    else if (turn)
    begin
      out_sr <= (cmd == `SPR_CMD_TRD) ? rd_byte : hold;
      prog_serial_data_out.oe <= 1'b1;
    end
    else if (rise && prog_serial_data_out.oe)
    begin
      prog_serial_data_out.dout <= out_sr[0];
      out_sr <= {1'b0, out_sr[7:1]};
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  logic aw_got, w_got, wd0;
  logic [7:0] awa;

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == `SPR_A_CTRL || a == `SPR_A_STAT || a == `SPR_A_PTR || a == `SPR_A_HOLD;
  endfunction : mapped

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awa <= 8'h00;
      wd0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPR_OKAY;
      enable <= `SPR_CTRL_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got <= 1'b1;
        awa <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got <= 1'b1;
        wd0 <= s_axi_wstrb[0] ? s_axi_wdata[0] : enable;
      end
      if (aw_got && w_got)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awa) ? `SPR_OKAY : `SPR_SLVERR;
        if (awa == `SPR_A_CTRL)
          enable <= wd0;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SPR_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `SPR_OKAY : `SPR_SLVERR;
      case (s_axi_araddr)
        `SPR_A_CTRL: s_axi_rdata <= {31'h0, enable};
        `SPR_A_STAT: s_axi_rdata <= {24'h0, state, pend, prog_serial_data_out.oe, cmd};
        `SPR_A_PTR: s_axi_rdata <= {10'h0, tp};
        `SPR_A_HOLD: s_axi_rdata <= {16'h0, wreg, hold};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // Checks
  chk_cmd_lsb:
    assert property (cmd_done |=> cmd == {$past(din), $past(cmd_sr[3:1])})
    else $error("command not assembled lsb first");
  chk_wr_incr:
    assert property (flash_wr && cmd == `SPR_CMD_WRINC |=> tp == $past(tp) + 22'h000002)
    else $error("pointer not advanced by two");
  chk_cfg_noinc:
    assert property (cfg_wr |=> $stable(tp))
    else $error("config write moved pointer");
  chk_rd_incr:
    assert property (turn && cmd == `SPR_CMD_TRD |=> tp == $past(tp) + 22'h000001)
    else $error("read did not advance pointer");
  chk_rd_load:
    assert property (turn && cmd == `SPR_CMD_TRD |=> out_sr == $past(rd_byte))
    else $error("read byte not loaded");
  chk_hold_load:
    assert property (turn && cmd == `SPR_CMD_SHOUT |=> out_sr == $past(hold))
    else $error("holding latch not loaded");
  chk_oe_window:
    assert property (prog_serial_data_out.oe |-> state == SPR_PAY && is_read && cnt > `SPR_TURN)
    else $error("pin driven outside read window");
  chk_cfg_lock:
    assert property (commit && pend_cfg && wp |=> $stable(cfg_cur))
    else $error("protected config byte changed");
  chk_cfg_byte:
    assert property (commit && pend_cfg && !wp && region_of(pend_base) == SPR_RG_CFG
                     |=> cfg_cur == $past(pend_byte))
    else $error("config byte not written");
  chk_prog_end:
    assert property (pend && !commit |=> pend)
    else $error("programming ended early");
  chk_axi_b:
    assert property (aw_got && w_got |=> s_axi_bvalid)
    else $error("write response missing");

  cov_table_read: cover property (turn && cmd == `SPR_CMD_TRD ##[1:300] pay_done);
  cov_code_prog: cover property (commit && !pend_cfg);
  cov_cfg_prog: cover property (commit && pend_cfg);
  cov_ee_shout: cover property (turn && cmd == `SPR_CMD_SHOUT);
endmodule : spr_serial_port
`default_nettype wire

// [testbench/spr_prog_model.sv]
// Programmer model: drives serial clock and data, samples read bytes
`default_nettype none
module spr_prog_model (
  output logic clk_out,
  output logic data_out,
  input wire logic pin,
  output logic [7:0] rx_byte,
  output logic rx_done
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    clk_out = 1'b0;
    data_out = 1'b0;
    rx_byte = 8'h00;
    rx_done = 1'b0;
  end
  // ==========================================================
  // Bit and frame timing, clock idles low between frames
  // Data moves mid-high so it is stable across the sampling fall
  // Pin edges land on system clock edges, so nonblocking avoids races
  task automatic put_bit(input logic b);
    #200 clk_out <= 1'b1;
    #100 data_out <= b;
    #100 clk_out <= 1'b0;
  endtask : put_bit
  task automatic frame(input logic [3:0] cmd, input logic [15:0] pay);
    for (int i = 0; i < 4; i++) put_bit(cmd[i]);
    for (int i = 0; i < 16; i++) put_bit(pay[i]);
    #400;
  endtask : frame
  task automatic read_frame(input logic [3:0] cmd);
    for (int i = 0; i < 4; i++) put_bit(cmd[i]);
    for (int i = 0; i < 8; i++) put_bit(1'b0);
    // Released line shows the inverse of the last level
    data_out <= 1'b1;
    #400;
    for (int i = 0; i < 8; i++)
    begin
      #200 clk_out <= 1'b1;
      #199 rx_byte[i] = pin;
      #1 clk_out <= 1'b0;
    end
    rx_done = 1'b1;
    #400 rx_done = 1'b0;
    data_out <= 1'b0;
  endtask : read_frame
endmodule : spr_prog_model
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the serial programming port
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import spr_pkg::*;
  logic sys_clk, rst, link_clk, prog_drv, pin, rx_done;
  logic [7:0] rx_byte, awaddr, araddr;
  spr_pin_t dout;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic [3:0] wstrb;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [33:0] axi_q[$];
  logic [7:0] ser_q[$];
  logic [7:0] id[8];
  logic [15:0] cw;
  int miscompares, total_checks;
  // Pin resolves to the device while it enables, else the programmer
  assign pin = dout.oe ? dout.dout : prog_drv;
  spr_serial_port #(.CODE_BYTES(2048)) spr_serial_port_inst (.sys_clk(sys_clk), .rst(rst),
    .prog_serial_clock(link_clk), .prog_serial_data_in(pin), .prog_serial_data_out(dout),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  spr_prog_model spr_prog_model_inst (.clk_out(link_clk), .data_out(prog_drv), .pin(pin),
    .rx_byte(rx_byte), .rx_done(rx_done));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Checking
  task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic test_done();
    if (axi_q.size() + ser_q.size() != 0) miscompares++;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic timeout();
    $display("[FAIL] handshake expected within bound seen none");
    miscompares++;
    test_done();
  endtask : timeout
  always @(posedge sys_clk)
  begin
    if (bvalid && bready) check("bresp", axi_q.pop_front(), {bresp, 32'h0});
    if (rvalid && rready) check("rdata", axi_q.pop_front(), {rresp, rdata});
  end
  always @(posedge rx_done) check("serial byte", {26'h0, ser_q.pop_front()}, {26'h0, rx_byte});
  // ==========================================================
  // Bus and serial drivers
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    axi_q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
      if (n > 100) timeout();
    end
    while (!(bvalid && bready));
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    axi_q.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
      if (n > 100) timeout();
    end
    while (!(rvalid && rready));
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_rd
  task automatic core_op(input logic [15:0] p);
    spr_prog_model_inst.frame(4'h0, p);
  endtask : core_op
  task automatic set_ptr(input logic [21:0] a);
    core_op({8'h0e, 2'b00, a[21:16]});
    core_op(16'h6ef8);
    core_op({8'h0e, a[15:8]});
    core_op(16'h6ef7);
    core_op({8'h0e, a[7:0]});
    core_op(16'h6ef6);
  endtask : set_ptr
  task automatic trd(input logic [7:0] e);
    ser_q.push_back(e);
    spr_prog_model_inst.read_frame(4'h9);
  endtask : trd
  task automatic prog(input logic [15:0] p);
    spr_prog_model_inst.frame(4'hf, p);
    core_op(16'h0000);
  endtask : prog
  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    miscompares = 0;
    total_checks = 0;
    cw = 16'($urandom(27));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    axi_rd(8'h00, 32'h1, 2'h0);
    axi_rd(8'h04, 32'h40, 2'h0);
    axi_rd(8'h10, 32'h0, 2'h2);
    axi_wr(8'h10, 32'h0, 2'h2);
    axi_wr(8'h08, 32'hffffffff, 2'h0);
    axi_rd(8'h08, 32'h0, 2'h0);
    axi_wr(8'h00, 32'h0, 2'h0);
    axi_rd(8'h00, 32'h0, 2'h0);
    axi_rd(8'h04, 32'h0, 2'h0);
    // Masked byte lane must leave the enable untouched
    wstrb <= 4'h0;
    axi_wr(8'h00, 32'h1, 2'h0);
    axi_rd(8'h00, 32'h0, 2'h0);
    wstrb <= 4'hf;
    axi_wr(8'h00, 32'h1, 2'h0);
    $display("Test registers done");
    core_op(16'h8ea6);
    core_op(16'h9ca6);
    set_ptr(22'h200000);
    axi_rd(8'h08, 32'h200000, 2'h0);
    for (int i = 0; i < 8; i++) id[i] = 8'($urandom);
    for (int i = 0; i < 6; i += 2) spr_prog_model_inst.frame(4'hd, {id[i+1], id[i]});
    prog({id[7], id[6]});
    axi_rd(8'h08, 32'h200006, 2'h0);
    set_ptr(22'h200000);
    for (int i = 0; i < 8; i++) trd(id[i]);
    axi_rd(8'h08, 32'h200008, 2'h0);
    set_ptr(22'h0007fe);
    prog(cw);
    set_ptr(22'h0007fe);
    trd(cw[7:0]);
    trd(cw[15:8]);
    $display("Test code and identification done");
    cw = 16'($urandom);
    core_op(16'h8ca6);
    set_ptr(22'h300000);
    prog(cw);
    core_op(16'h0e01);
    core_op(16'h6ef6);
    prog(cw);
    axi_rd(8'h08, 32'h300001, 2'h0);
    set_ptr(22'h30000b);
    prog(16'hdf00);
    set_ptr(22'h300002);
    prog(16'h0000);
    set_ptr(22'h300000);
    trd(cw[7:0]);
    trd(cw[15:8]);
    trd(8'hff);
    set_ptr(22'h30000b);
    trd(8'hdf);
    $display("Test configuration done");
    cw = 16'($urandom);
    core_op(16'h9ea6);
    core_op(16'h9ca6);
    core_op({8'h0e, cw[7:0]});
    core_op(16'h6ea8);
    core_op(16'h0e00);
    core_op(16'h50a8);
    core_op(16'h6ef5);
    axi_rd(8'h0c, {16'h0, cw[7:0], cw[7:0]}, 2'h0);
    ser_q.push_back(cw[7:0]);
    spr_prog_model_inst.read_frame(4'h2);
    // Data register cleared first so only a real array read can show ones
    core_op({8'h0e, cw[15:8]});
    core_op(16'h6ea9);
    core_op(16'h0e00);
    core_op(16'h6eaa);
    core_op(16'h6ea8);
    core_op(16'h80a6);
    core_op(16'h50a8);
    core_op(16'h6ef5);
    ser_q.push_back(8'hff);
    spr_prog_model_inst.read_frame(4'h2);
    $display("Test holding latch done");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
